// ==== sensor_config_status_reg.sv ====
// Configuration and status register of the sensor with its serial command link
// Function
// - Supply-low flag in bit 6 is read-only, refreshed only during a measurement.
// - Bit 2 is the heater enable, reset 0 (off), 1 turns heater on.
// - Bit 1 set skips the calibration reload before each measurement.
// - Bit 1 clear requests a calibration reload before every measurement.
// - Bit 0 selects resolution: 1 is 8/12 bit, 0 is 12/14 bit.
// - Command 00111 reads the register, 00110 writes it.
// - Soft-reset command 11110 returns all writable bits to defaults.
// - Checksum seeds from the low nibble of the register, bit-reversed into the upper nibble, low bits zero.
module sensor_config_status_reg (
  // Core clock, reset and freeze
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire logic                     ce,
  // Serial link: clock from the host and the open-drain data pin
  input  wire logic                     sck,
  input  wire logic                     data_in,
  output logic                          data_out,
  output logic                          data_oe_n,
  // Measurement engine side
  input  wire logic                     supply_low_in,
  input  wire logic                     meas_busy,
  output logic                          meas_req,
  output logic                          meas_humid,
  output logic                          otp_reload_req,
  // Register contents driving the sensor
  output sensor_cfg_pkg::status_t       status_q
);

  // ---------------- Core domain signals ----------------
  logic [sensor_cfg_pkg::W_CORE_SYNC-1:0] c_sync;
  logic [3:0]                             c_prev_ff;
  sensor_cfg_pkg::status_t                status_ff;
  sensor_cfg_pkg::status_t                nxt_status;
  logic [7:0]                             pub_word_ff;
  logic                                   pub_tgl_ff;
  logic                                   meas_req_ff;
  logic                                   meas_humid_ff;
  logic                                   otp_reload_ff;

  // ---------------- Link domain signals ----------------
  logic [sensor_cfg_pkg::W_LINK_SYNC-1:0] l_sync;
  logic                                   l_rst;
  sensor_cfg_pkg::link_state_t            state_ff;
  sensor_cfg_pkg::link_state_t            nxt_state;
  logic [2:0]                             cnt_ff;
  logic [7:0]                             shift_ff;
  logic [7:0]                             crc_ff;
  logic [7:0]                             nxt_crc;
  logic [7:0]                             shadow_ff;
  logic [7:0]                             tx_ff;
  logic [4:0]                             cmd_ff;
  logic [3:0]                             high_cnt_ff;
  logic                                   smp_ff;
  logic                                   fell_ff;
  logic                                   pub_prev_ff;
  logic                                   ack_tgl_ff;
  logic                                   wr_tgl_ff;
  logic                                   srst_tgl_ff;
  logic                                   meas_tgl_ff;
  logic                                   meas_kind_ff;
  logic [7:0]                             wr_data_ff;
  logic                                   drive_low_ff;
  logic                                   data_out_ff;

  // Core-side edge events of the link toggles
  wire        wr_ev    = c_sync[0] ^ c_prev_ff[0];
  wire        srst_ev  = c_sync[1] ^ c_prev_ff[1];
  wire        meas_ev  = c_sync[2] ^ c_prev_ff[2];
  wire        ack_back = c_sync[3];
  wire        supply_s = c_sync[4];
  wire        pub_free = (ack_back == pub_tgl_ff);
  wire [7:0]  stat_rd  = status_ff & sensor_cfg_pkg::RD_MASK;
  wire        pub_need = pub_free && (pub_word_ff != stat_rd);

  // Synchronisers for toggles and the comparator level into the core
  cdc_sync2 #(.W(sensor_cfg_pkg::W_CORE_SYNC)) u_core_sync (
    .clk (core_clk),
    .en  (ce),
    .d   ({supply_low_in, ack_tgl_ff, meas_tgl_ff, srst_tgl_ff, wr_tgl_ff}),
    .q   (c_sync)
  );

  // Register next value: soft reset beats write, flag only follows during measurement
  wire [7:0] wr_merge = (status_ff & ~sensor_cfg_pkg::WR_MASK) |
                        (wr_data_ff & sensor_cfg_pkg::WR_MASK);
  wire [7:0] rst_merge = (status_ff & ~sensor_cfg_pkg::WR_MASK) |
                         (sensor_cfg_pkg::STATUS_RESET & sensor_cfg_pkg::WR_MASK);
  wire [7:0] base_next = srst_ev ? rst_merge : (wr_ev ? wr_merge : status_ff);
  always_comb begin
    nxt_status                 = sensor_cfg_pkg::status_t'(base_next);
    nxt_status.rsv7            = 1'b0;
    nxt_status.rsv5            = 1'b0;
    nxt_status.rsv4            = 1'b0;
    nxt_status.supply_low_flag = meas_busy ? supply_s : status_ff.supply_low_flag;
  end

  // Core registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      status_ff <= sensor_cfg_pkg::status_t'(sensor_cfg_pkg::STATUS_RESET);
      c_prev_ff <= 4'h0;
    end else if (ce) begin
      status_ff <= nxt_status;
      c_prev_ff <= c_sync[3:0];
    end
  end

  // Measurement request and calibration reload pulses
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meas_req_ff   <= 1'b0;
      meas_humid_ff <= 1'b0;
      otp_reload_ff <= 1'b0;
    end else if (ce) begin
      meas_req_ff   <= meas_ev;
      otp_reload_ff <= meas_ev & ~status_ff.no_reload;
      if (meas_ev) begin
        meas_humid_ff <= meas_kind_ff;
      end
    end
  end

  // Publish the register word to the link side, one handshake at a time
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pub_word_ff <= sensor_cfg_pkg::STATUS_RESET;
      pub_tgl_ff  <= 1'b0;
    end else if (ce && pub_need) begin
      pub_word_ff <= stat_rd;
      pub_tgl_ff  <= ~pub_tgl_ff;
    end
  end

  // ---------------- Link domain ----------------
  cdc_sync2 #(.W(sensor_cfg_pkg::W_LINK_SYNC)) u_link_sync (
    .clk (sck),
    .en  (1'b1),
    .d   ({nrst, pub_tgl_ff}),
    .q   (l_sync)
  );
  assign l_rst = ~l_sync[1];

  // Link decode
  wire [7:0] rx_byte  = {shift_ff[6:0], data_in};
  wire       last_bit = (cnt_ff == sensor_cfg_pkg::LAST_BIT);
  wire       conn_rst = (high_cnt_ff >= sensor_cfg_pkg::CONN_RST_CNT);
  wire [7:0] crc_seed = {shadow_ff[0], shadow_ff[1], shadow_ff[2], shadow_ff[3], 4'h0};
  wire       tx_bit   = tx_ff[3'(sensor_cfg_pkg::LAST_BIT - cnt_ff)];
  wire       is_read  = (cmd_ff == sensor_cfg_pkg::CMD_STAT_RD);
  wire       is_write = (cmd_ff == sensor_cfg_pkg::CMD_STAT_WR);
  wire       is_meas  = (cmd_ff == sensor_cfg_pkg::CMD_MEAS_T) ||
                        (cmd_ff == sensor_cfg_pkg::CMD_MEAS_RH);
  wire       is_srst  = (cmd_ff == sensor_cfg_pkg::CMD_SOFT_RST);

  // Frame state machine, advanced on each rising clock edge
  always_comb begin
    nxt_state = state_ff;
    nxt_crc   = crc_ff;
    case (state_ff)
      sensor_cfg_pkg::L_IDLE: nxt_state = sensor_cfg_pkg::L_IDLE;
      sensor_cfg_pkg::L_CMD: begin
        nxt_crc = sensor_cfg_pkg::crc_step(crc_ff, data_in);
        if (last_bit) begin
          nxt_state = sensor_cfg_pkg::cmd_known(rx_byte) ? sensor_cfg_pkg::L_CACK
                                                          : sensor_cfg_pkg::L_IDLE;
        end
      end
      sensor_cfg_pkg::L_CACK: begin
        if (is_read) begin
          nxt_state = sensor_cfg_pkg::L_RDAT;
        end else if (is_write) begin
          nxt_state = sensor_cfg_pkg::L_WDAT;
        end else begin
          nxt_state = sensor_cfg_pkg::L_IDLE;
        end
      end
      sensor_cfg_pkg::L_WDAT: if (last_bit) nxt_state = sensor_cfg_pkg::L_WACK;
      sensor_cfg_pkg::L_WACK: nxt_state = sensor_cfg_pkg::L_IDLE;
      sensor_cfg_pkg::L_RDAT: begin
        nxt_crc = sensor_cfg_pkg::crc_step(crc_ff, tx_bit);
        if (last_bit) nxt_state = sensor_cfg_pkg::L_RACK;
      end
      sensor_cfg_pkg::L_RACK: nxt_state = data_in ? sensor_cfg_pkg::L_IDLE
                                                  : sensor_cfg_pkg::L_RCRC;
      sensor_cfg_pkg::L_RCRC: if (last_bit) nxt_state = sensor_cfg_pkg::L_RCACK;
      sensor_cfg_pkg::L_RCACK: nxt_state = sensor_cfg_pkg::L_IDLE;
      default: nxt_state = sensor_cfg_pkg::L_IDLE;
    endcase
    if (fell_ff) begin
      nxt_state = sensor_cfg_pkg::L_CMD;
      nxt_crc   = crc_seed;
    end else if (conn_rst) begin
      nxt_state = sensor_cfg_pkg::L_IDLE;
    end
  end

  // State, bit counter, sampling and checksum
  always_ff @(posedge sck) begin
    if (l_rst) begin
      state_ff    <= sensor_cfg_pkg::L_IDLE;
      cnt_ff      <= 3'h0;
      crc_ff      <= 8'h00;
      smp_ff      <= 1'b1;
      high_cnt_ff <= 4'h0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= (nxt_state != state_ff) ? 3'h0 : 3'(cnt_ff + 3'h1);
      crc_ff      <= nxt_crc;
      smp_ff      <= data_in;
      high_cnt_ff <= data_in ? (conn_rst ? high_cnt_ff : 4'(high_cnt_ff + 4'h1)) : 4'h0;
    end
  end

  // Shift register, command capture and transmit byte
  always_ff @(posedge sck) begin
    if (l_rst) begin
      shift_ff <= 8'h00;
      cmd_ff   <= 5'h00;
      tx_ff    <= 8'h00;
    end else begin
      shift_ff <= rx_byte;
      if (state_ff == sensor_cfg_pkg::L_CMD && last_bit) cmd_ff <= rx_byte[4:0];
      if (state_ff == sensor_cfg_pkg::L_CACK) tx_ff <= shadow_ff;
    end
  end

  // Toggles and held words towards the core
  always_ff @(posedge sck) begin
    if (l_rst) begin
      wr_tgl_ff    <= 1'b0;
      srst_tgl_ff  <= 1'b0;
      meas_tgl_ff  <= 1'b0;
      meas_kind_ff <= 1'b0;
      wr_data_ff   <= 8'h00;
    end else begin
      if (state_ff == sensor_cfg_pkg::L_WDAT && last_bit) begin
        wr_data_ff <= rx_byte;
        wr_tgl_ff  <= ~wr_tgl_ff;
      end
      if (state_ff == sensor_cfg_pkg::L_CACK && is_srst) srst_tgl_ff <= ~srst_tgl_ff;
      if (state_ff == sensor_cfg_pkg::L_CACK && is_meas) begin
        meas_tgl_ff  <= ~meas_tgl_ff;
        meas_kind_ff <= (cmd_ff == sensor_cfg_pkg::CMD_MEAS_RH);
      end
    end
  end

  // Shadow copy of the register taken on each published toggle
  always_ff @(posedge sck) begin
    if (l_rst) begin
      shadow_ff   <= sensor_cfg_pkg::STATUS_RESET;
      pub_prev_ff <= 1'b0;
      ack_tgl_ff  <= 1'b0;
    end else begin
      pub_prev_ff <= l_sync[0];
      if (l_sync[0] != pub_prev_ff) begin
        shadow_ff  <= pub_word_ff;
        ack_tgl_ff <= l_sync[0];
      end
    end
  end

  // Falling edge: start detect and data pin drive for the coming bit slot
  wire drive_now = (state_ff == sensor_cfg_pkg::L_CACK) ||
                   (state_ff == sensor_cfg_pkg::L_WACK) ||
                   (state_ff == sensor_cfg_pkg::L_RDAT && !tx_bit) ||
                   (state_ff == sensor_cfg_pkg::L_RCRC && !crc_ff[cnt_ff]);
  always_ff @(negedge sck) begin
    if (l_rst) begin
      fell_ff      <= 1'b0;
      drive_low_ff <= 1'b0;
      data_out_ff  <= 1'b0;
    end else begin
      fell_ff      <= smp_ff & ~data_in;
      drive_low_ff <= drive_now;
      data_out_ff  <= 1'b0;                                         // Open drain only pulls low
    end
  end

  // Outputs from flip-flops
  assign data_out       = data_out_ff;
  assign data_oe_n      = ~drive_low_ff;
  assign meas_req       = meas_req_ff;
  assign meas_humid     = meas_humid_ff;
  assign otp_reload_req = otp_reload_ff;
  assign status_q       = status_ff;

endmodule

// ==== sensor_cfg_sync.sv ====
// Shared constants and types for the sensor configuration block, plus a two-stage synchroniser
package sensor_cfg_pkg;
  // Command byte: three address bits then a five-bit command code
  localparam logic [2:0] ADDR_DEV     = 3'h0;
  localparam logic [4:0] CMD_MEAS_T   = 5'h03;
  localparam logic [4:0] CMD_MEAS_RH  = 5'h05;
  localparam logic [4:0] CMD_STAT_RD  = 5'h07;
  localparam logic [4:0] CMD_STAT_WR  = 5'h06;
  localparam logic [4:0] CMD_SOFT_RST = 5'h1e;
  // Register layout
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] WR_MASK      = 8'h0f;  // Bits 3..0 take host writes
  localparam logic [7:0] RD_MASK      = 8'h4f;  // Reserved bits read as zero
  localparam logic [7:0] CRC_POLY     = 8'h31;  // Feedback taps at bits 5, 4 and 0
  // Link bit counting
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [3:0] CONN_RST_CNT = 4'h9;   // High bits that abort any frame
  // Synchroniser lanes, core side and link side
  localparam int         W_CORE_SYNC  = 5;
  localparam int         W_LINK_SYNC  = 2;

  typedef struct packed {
    logic rsv7;
    logic supply_low_flag;
    logic rsv5;
    logic rsv4;
    logic test;
    logic heater;
    logic no_reload;
    logic res_low;
  } status_t;

  typedef enum logic [3:0] {
    L_IDLE  = 4'b0000,
    L_CMD   = 4'b0001,
    L_CACK  = 4'b0010,
    L_WDAT  = 4'b0011,
    L_WACK  = 4'b0100,
    L_RDAT  = 4'b0101,
    L_RACK  = 4'b0110,
    L_RCRC  = 4'b0111,
    L_RCACK = 4'b1000
  } link_state_t;

  // One step of the bitwise checksum generator
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
    logic [7:0] sh;
    sh = {crc[6:0], 1'b0};
    crc_step = (din ^ crc[7]) ? (sh ^ CRC_POLY) : sh;
  endfunction

  // True for a command byte the device answers
  function automatic logic cmd_known(input logic [7:0] b);
    logic [4:0] c;
    c = b[4:0];
    cmd_known = (b[7:5] == ADDR_DEV) &&
                (c == CMD_MEAS_T || c == CMD_MEAS_RH || c == CMD_STAT_RD ||
                 c == CMD_STAT_WR || c == CMD_SOFT_RST);
  endfunction
endpackage

// Two flip-flop synchroniser; the first stage feeds only the second
module cdc_sync2 #(
  parameter int W = 1
) (
  // Clock and freeze
  input  wire logic         clk,
  input  wire logic         en,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // Two stages in series
  always_ff @(posedge clk) begin
    if (en) begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// ==== sensor_config_status_reg_checker.sv ====
// Port assertions for the sensor configuration register
module sensor_config_status_reg_checker (
  // Core side
  input wire logic                    core_clk,
  input wire logic                    nrst,
  input wire logic                    meas_busy,
  input wire logic                    meas_req,
  input wire logic                    otp_reload_req,
  input wire sensor_cfg_pkg::status_t status_q,
  // Link side
  input wire logic                    sck,
  input wire logic                    data_out,
  input wire logic                    data_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // Stored bits and request pulses, core clock domain
  AST_RSV_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    {status_q.rsv7, status_q.rsv5, status_q.rsv4} == 3'h0)
    else $error("reserved status bit set");
  AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !meas_busy [*2] |=> $stable(status_q.supply_low_flag))
    else $error("supply flag moved outside a measurement");
  AST_RELOAD: assert property (@(posedge core_clk) disable iff (!nrst)
    meas_req && !status_q.no_reload |-> otp_reload_req)
    else $error("calibration reload missing");
  AST_SKIP: assert property (@(posedge core_clk) disable iff (!nrst)
    meas_req && status_q.no_reload |-> !otp_reload_req)
    else $error("calibration reload not skipped");
  AST_OTP_PAIR: assert property (@(posedge core_clk) disable iff (!nrst)
    otp_reload_req |-> meas_req)
    else $error("reload request without measurement");
  AST_REQ_PULSE: assert property (@(posedge core_clk) disable iff (!nrst)
    meas_req |=> !meas_req)
    else $error("measure request longer than one cycle");
  // Open-drain pin never driven high, on the link clock
  AST_OPEN_DRAIN: assert property (@(posedge sck) disable iff (!nrst)
    data_out == 1'b0)
    else $error("data pin driven high");
  // Enable moves only while the link clock is low, seen at core resolution
  AST_OE_ON_FALL: assert property (@(posedge core_clk) disable iff (!nrst)
    $changed(data_oe_n) |-> !sck)
    else $error("data enable changed while link clock high");

  // Main scenarios
  COV_RELOAD: cover property (@(posedge core_clk) meas_req && otp_reload_req);
  COV_SKIP: cover property (@(posedge core_clk) meas_req && status_q.no_reload);
  COV_FLAG: cover property (@(posedge core_clk) $rose(status_q.supply_low_flag));
endmodule

bind sensor_config_status_reg sensor_config_status_reg_checker CHK (
  .core_clk(core_clk), .nrst(nrst), .meas_busy(meas_busy), .meas_req(meas_req),
  .otp_reload_req(otp_reload_req), .status_q(status_q), .sck(sck),
  .data_out(data_out), .data_oe_n(data_oe_n)
);

// ==== host_link_model.sv ====
// Host microcontroller model for the two-wire command link
module host_link_model (
  // Link wires
  output logic      sck,
  output logic      host_low,
  input  wire logic data_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // Clock stands low and DATA released outside frames
  initial begin
    sck      = 1'b0;
    host_low = 1'b0;
  end

  // One bit: set DATA a little after the fall so the device's fall sampler sees the old level
  task automatic bit_cell(input logic b, output logic r);
    #8 host_low = ~b;
    #24 sck = 1'b1;
    #16 r = data_in;
    #16 sck = 1'b0;
  endtask

  // Ten clocks with DATA high clear any half-done frame
  task automatic idle_clocks();
    logic r;
    #5;
    repeat (10) bit_cell(1'b1, r);
  endtask

  // DATA falls while the clock is high, then a low start phase
  task automatic start_frame();
    logic r;
    idle_clocks();
    #32 sck = 1'b1;
    #16 host_low = 1'b1;
    #16 sck = 1'b0;
    bit_cell(1'b0, r);
  endtask

  // Byte out MSB first, then release for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cell(b[i], r);
    bit_cell(1'b1, ack);
  endtask

  // Byte in MSB first, then acknowledge low or leave high
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(1'b1, r);
      d[i] = r;
    end
    bit_cell(~ack, r);
  endtask

  // One-byte command frame
  task automatic command(input logic [7:0] b, output logic a);
    start_frame();
    send_byte(b, a);
  endtask

  // Register write; the test bit always goes out as zero
  task automatic write_status(input logic [7:0] v, output logic a0, output logic a1);
    command(8'h06, a0);
    send_byte(v & 8'hf7, a1);
  endtask

  // Register read with checksum, last byte left unacknowledged
  task automatic read_status(output logic [7:0] v, output logic [7:0] c, output logic a);
    command(8'h07, a);
    recv_byte(1'b1, v);
    recv_byte(1'b0, c);
  endtask
endmodule

// ==== sensor_config_status_reg_tb.sv ====
// Self-checking testbench for the sensor configuration register
module sensor_config_status_reg_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                    core_clk;
  logic                    nrst;
  logic                    ce;
  logic                    sck;
  logic                    host_low;
  logic                    data_in;
  logic                    data_out;
  logic                    data_oe_n;
  logic                    supply_low_in;
  logic                    meas_busy;
  logic                    meas_req;
  logic                    meas_humid;
  logic                    otp_reload_req;
  sensor_cfg_pkg::status_t status_q;
  int                      req_cnt = 0;
  int                      otp_cnt = 0;
  logic                    last_hum = 1'b0;
  int                      failures;
  int                      checks;

  // Pulled-up DATA wire: low when either party pulls it
  assign data_in = !host_low && !(data_oe_n === 1'b0 && data_out !== 1'b1);

  sensor_config_status_reg DUT (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .sck(sck), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .supply_low_in(supply_low_in),
    .meas_busy(meas_busy), .meas_req(meas_req), .meas_humid(meas_humid),
    .otp_reload_req(otp_reload_req), .status_q(status_q)
  );

  host_link_model HOST (.sck(sck), .host_low(host_low), .data_in(data_in));

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Count measurement requests mid-cycle, where the pulse has settled
  always @(negedge core_clk) begin
    if (meas_req === 1'b1) begin
      req_cnt  <= req_cnt + 1;
      otp_cnt  <= otp_cnt + int'(otp_reload_req === 1'b1);
      last_hum <= meas_humid;
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask

  // Received checksum: seed from reversed low nibble, sent bit-reversed
  function automatic logic [7:0] crc_rx(input logic [3:0] s, input logic [15:0] m);
    logic [7:0] c;
    logic [7:0] r;
    c = {s[0], s[1], s[2], s[3], 4'h0};
    for (int i = 15; i >= 0; i--) c = (m[i] ^ c[7]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    for (int i = 0; i < 8; i++) r[i] = c[7 - i];
    return r;
  endfunction

  task automatic read_check(input logic [7:0] exp);
    logic [7:0] v;
    logic [7:0] c;
    logic       a;
    HOST.read_status(v, c, a);
    check1(a, 1'b0);
    check8(v, exp);
    check8(c, crc_rx(exp[3:0], {8'h07, exp}));
  endtask

  // Command with expected acknowledge, then time for the core to follow
  task automatic cmd_check(input logic [7:0] b, input logic exp_ack);
    logic a;
    HOST.command(b, a);
    check1(a, exp_ack);
    repeat (125) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] v);
    logic a0;
    logic a1;
    HOST.write_status(v, a0, a1);
    check8({6'h00, a0, a1}, 8'h00);
    repeat (125) @(negedge core_clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    supply_low_in = 1'b0;
    meas_busy = 1'b0;
    failures = 0;
    checks = 0;
    repeat (4) @(negedge core_clk);
    HOST.idle_clocks();
    @(negedge core_clk);
    nrst = 1'b1;
    check8(status_q, 8'h00);
    read_check(8'h00);
    wr(8'hb7);
    check8(status_q, 8'h07);
    read_check(8'h07);
    cmd_check(8'h03, 1'b0);
    check8(8'(req_cnt), 8'h01);
    check8(8'(otp_cnt), 8'h00);
    check1(last_hum, 1'b0);
    // Supply flag moves only while a measurement runs
    supply_low_in = 1'b1;
    repeat (20) @(negedge core_clk);
    check1(status_q.supply_low_flag, 1'b0);
    meas_busy = 1'b1;
    repeat (10) @(negedge core_clk);
    meas_busy = 1'b0;
    supply_low_in = 1'b0;
    repeat (10) @(negedge core_clk);
    check1(status_q.supply_low_flag, 1'b1);
    wr(8'h00);
    check8(status_q, 8'h40);
    read_check(8'h40);
    cmd_check(8'h05, 1'b0);
    check8(8'(req_cnt), 8'h02);
    check8(8'(otp_cnt), 8'h01);
    check1(last_hum, 1'b1);
    wr(8'h05);
    check8(status_q, 8'h45);
    cmd_check(8'h1e, 1'b0);
    check8(status_q, 8'h40);
    // Core frozen: a write lands only once the clock enable returns
    ce = 1'b0;
    wr(8'h02);
    check8(status_q, 8'h40);
    ce = 1'b1;
    repeat (20) @(negedge core_clk);
    check8(status_q, 8'h42);
    cmd_check(8'h09, 1'b1);
    cmd_check(8'he7, 1'b1);
    read_check(8'h42);
    print_verdict();
  end

  // Watchdog
  initial begin
    #300000;
    failures++;
    print_verdict();
  end
endmodule
